// [tbps_top.sv]
// two free-running timebase counters with clock select and prescalers,
// control and counts reached over an axi4-lite slave
// assumes ext_clk_in phases of two system clocks or more
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module tbps_top
    import tbps_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic             ext_clk_in,
    output logic [CNT_W-1:0]      tb1_count,
    output logic [CNT_W-1:0]      tb2_count
);
    import tbps_pkg::*;

    // true when the prescaler counter completes a group of 2**code ticks
    function automatic logic presc_hit(input logic [2:0] cnt, input logic [1:0] code);
        logic [2:0] mask;
        mask = 3'((4'h1 << code) - 4'h1);
        return (cnt & mask) == mask;
    endfunction : presc_hit

    // word-aligned decode shared by reads and writes
    function automatic logic is_mapped(input logic [7:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'h0};
        if (w == ADDR_CTRL) return 1'b1;
        else if (w == ADDR_TB1) return 1'b1;
        else if (w == ADDR_TB2) return 1'b1;
        else return 1'b0;
    endfunction : is_mapped

    logic             aw_full_reg, aw_full_next;
    logic [7:0]       awaddr_reg, awaddr_next;
    logic             w_full_reg, w_full_next;
    logic [31:0]      wdata_reg, wdata_next;
    logic [3:0]       wstrb_reg, wstrb_next;
    logic             bvalid_reg, bvalid_next;
    logic [1:0]       bresp_reg, bresp_next;
    logic             rvalid_reg, rvalid_next;
    logic [31:0]      rdata_reg, rdata_next;
    logic [1:0]       rresp_reg, rresp_next;
    logic [7:0]       ctrl_reg, ctrl_next;
    logic             wr_go;
    logic             wr_ctrl;
    logic [4:0]       div_reg, div_next;
    logic [4:0]       div_lim;
    logic             src1_tick;
    logic [2:0]       pc1_reg, pc1_next;
    logic             tb1_tick;
    logic [CNT_W-1:0] tb1_reg, tb1_next;
    logic             sy1_reg, sy2_reg, sy3_reg;
    logic             rise_ev, fall_ev;
    logic [1:0]       mode2;
    logic             src2_tick;
    logic [2:0]       pc2_reg, pc2_next;
    logic             tb2_tick;
    logic [CNT_W-1:0] tb2_reg, tb2_next;
    logic [4:0]       gap_reg, gap_next;
    logic             dirty_reg, dirty_next;

    // handshake outputs are plain decodes of the holding flags
    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready  = !w_full_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign tb1_count     = tb1_reg;
    assign tb2_count     = tb2_reg;

    // write channel: address and data latched in either order, then one commit
    always_comb begin
        aw_full_next = aw_full_reg;
        awaddr_next  = awaddr_reg;
        w_full_next  = w_full_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        ctrl_next    = ctrl_reg;
        if (s_axi_awvalid && !aw_full_reg) begin
            aw_full_next = 1'b1;
            awaddr_next  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_full_reg) begin
            w_full_next = 1'b1;
            wdata_next  = s_axi_wdata;
            wstrb_next  = s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        // commit waits for the previous response so no answer is overwritten
        wr_go   = aw_full_reg && w_full_reg && !bvalid_reg;
        wr_ctrl = wr_go && ({awaddr_reg[7:2], 2'h0} == ADDR_CTRL) && wstrb_reg[0];
        if (wr_go) begin
            aw_full_next = 1'b0;
            w_full_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = is_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLV;
        end
        if (wr_ctrl) begin
            ctrl_next = wdata_reg[7:0];
        end
    end

    // read channel: one outstanding read, data captured at the address handshake
    always_comb begin
        logic [7:0] ra;
        ra          = {s_axi_araddr[7:2], 2'h0};
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rresp_next  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLV;
            if (ra == ADDR_CTRL) rdata_next = {24'h000000, ctrl_reg};
            else if (ra == ADDR_TB1) rdata_next = 32'(tb1_reg);
            else if (ra == ADDR_TB2) rdata_next = 32'(tb2_reg);
            else rdata_next = 32'h00000000;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            awaddr_reg  <= 8'h00;
            w_full_reg  <= 1'b0;
            wdata_reg   <= 32'h00000000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h00000000;
            rresp_reg   <= RESP_OKAY;
            ctrl_reg    <= CTRL_RESET;
        end else begin
            aw_full_reg <= aw_full_next;
            awaddr_reg  <= awaddr_next;
            w_full_reg  <= w_full_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
            ctrl_reg    <= ctrl_next;
        end
    end

    // timebase one: source divider, 3-bit prescaler, counter
    always_comb begin
        if (ctrl_reg[CTRL_BYP]) div_lim = HALF_LIM;
        else if (ctrl_reg[CTRL_PSCK]) div_lim = DIV4_LIM;
        else div_lim = DIV32_LIM;
        // >= so a shorter ratio written mid-count wraps at once
        src1_tick = (div_reg >= div_lim);
        div_next  = src1_tick ? 5'h00 : div_reg + 5'h01;
        pc1_next  = src1_tick ? pc1_reg + 3'h1 : pc1_reg;
        tb1_tick  = src1_tick && presc_hit(pc1_reg, ctrl_reg[CTRL_P1 +: 2]);
        tb1_next  = tb1_tick ? tb1_reg + 1'b1 : tb1_reg;
    end

    // timebase two: pick pin edges or gated sysclk, then prescale
    always_comb begin
        rise_ev   = sy2_reg && !sy3_reg;
        fall_ev   = !sy2_reg && sy3_reg;
        mode2     = {ctrl_reg[CTRL_GATE], ctrl_reg[CTRL_EDGE]};
        case (mode2)
            MODE_RISE:  src2_tick = rise_ev;
            MODE_FALL:  src2_tick = fall_ev;
            MODE_GATED: src2_tick = sy2_reg;
            default:    src2_tick = rise_ev || fall_ev;
        endcase
        pc2_next  = src2_tick ? pc2_reg + 3'h1 : pc2_reg;
        tb2_tick  = src2_tick && presc_hit(pc2_reg, ctrl_reg[CTRL_P2 +: 2]);
        tb2_next  = tb2_tick ? tb2_reg + 1'b1 : tb2_reg;
    end

    // checking aid: cycles since last divider tick, void after a control write
    always_comb begin
        gap_next   = src1_tick ? 5'h00 : (gap_reg == 5'h1f ? gap_reg : gap_reg + 5'h01);
        dirty_next = wr_ctrl || (dirty_reg && !src1_tick);
    end

    // sy1 feeds only sy2; edges are taken between sy2 and sy3
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_reg   <= 5'h00;
            pc1_reg   <= 3'h0;
            tb1_reg   <= '0;
            sy1_reg   <= 1'b0;
            sy2_reg   <= 1'b0;
            sy3_reg   <= 1'b0;
            pc2_reg   <= 3'h0;
            tb2_reg   <= '0;
            gap_reg   <= 5'h00;
            dirty_reg <= 1'b0;
        end else begin
            div_reg   <= div_next;
            pc1_reg   <= pc1_next;
            tb1_reg   <= tb1_next;
            sy1_reg   <= ext_clk_in;
            sy2_reg   <= sy1_reg;
            sy3_reg   <= sy2_reg;
            pc2_reg   <= pc2_next;
            tb2_reg   <= tb2_next;
            gap_reg   <= gap_next;
            dirty_reg <= dirty_next;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_div4;
        src1_tick && !dirty_reg && !ctrl_reg[CTRL_BYP] && ctrl_reg[CTRL_PSCK] |-> gap_reg == 5'h03;
    endproperty
    a_div4: assert property (p_div4) else $error("divide by 4 period wrong");

    property p_div32;
        src1_tick && !dirty_reg && !ctrl_reg[CTRL_BYP] && !ctrl_reg[CTRL_PSCK] |-> gap_reg == 5'h1f;
    endproperty
    a_div32: assert property (p_div32) else $error("divide by 32 period wrong");

    property p_half_rate_bypass;
        src1_tick && !dirty_reg && ctrl_reg[CTRL_BYP] |-> gap_reg == 5'h01;
    endproperty
    a_half_rate_bypass: assert property (p_half_rate_bypass) else $error("half rate period wrong");

    property p_tb1_code0;
        src1_tick && ctrl_reg[CTRL_P1 +: 2] == 2'h0 |=> tb1_reg == $past(tb1_reg) + 1'b1;
    endproperty
    a_tb1_code0: assert property (p_tb1_code0) else $error("tb1 missed undivided tick");

    property p_tb1_code3;
        src1_tick && ctrl_reg[CTRL_P1 +: 2] == 2'h3 && pc1_reg != 3'h7 |=> $stable(tb1_reg);
    endproperty
    a_tb1_code3: assert property (p_tb1_code3) else $error("tb1 stepped early in divide by 8");

    property p_tb_hold;
        !tb1_tick && !tb2_tick |=> $stable(tb1_reg) && $stable(tb2_reg);
    endproperty
    a_tb_hold: assert property (p_tb_hold) else $error("counter moved without tick");

    property p_rise;
        mode2 == MODE_RISE && ctrl_reg[CTRL_P2 +: 2] == 2'h0 && rise_ev |=> tb2_reg == $past(tb2_reg) + 1'b1;
    endproperty
    a_rise: assert property (p_rise) else $error("rising edge not counted");

    property p_fall;
        mode2 == MODE_FALL && ctrl_reg[CTRL_P2 +: 2] == 2'h0 |=> tb2_reg == $past(tb2_reg) + $past(fall_ev);
    endproperty
    a_fall: assert property (p_fall) else $error("falling edge count wrong");

    property p_both;
        mode2 == MODE_BOTH && ctrl_reg[CTRL_P2 +: 2] == 2'h0 && (rise_ev || fall_ev) |=>
            tb2_reg == $past(tb2_reg) + 1'b1;
    endproperty
    a_both: assert property (p_both) else $error("double edge not counted");

    property p_gated;
        mode2 == MODE_GATED && ctrl_reg[CTRL_P2 +: 2] == 2'h0 |=> tb2_reg == $past(tb2_reg) + $past(sy2_reg);
    endproperty
    a_gated: assert property (p_gated) else $error("gated clock count wrong");

    property p_tb2_code1;
        src2_tick && ctrl_reg[CTRL_P2 +: 2] == 2'h1 |=> tb2_reg == $past(tb2_reg) + $past(pc2_reg[0]);
    endproperty
    a_tb2_code1: assert property (p_tb2_code1) else $error("tb2 divide by 2 wrong");

    c_write: cover property (wr_ctrl ##1 bvalid_reg && s_axi_bready);
    c_read: cover property (s_axi_arvalid && !rvalid_reg ##1 rvalid_reg && s_axi_rready);
    c_tb1: cover property (tb1_tick && ctrl_reg[CTRL_P1 +: 2] == 2'h3);
    c_both: cover property (mode2 == MODE_BOTH && fall_ev ##[2:20] rise_ev);
endmodule : tbps_top
`default_nettype wire

// [tbps_pkg.sv]
// shared constants for the timebase prescaler and clock select block
// assumes a 32-bit axi4-lite master and one system clock
package tbps_pkg;
    // register byte addresses, one aligned word each
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_TB1   = 8'h04;
    localparam logic [7:0] ADDR_TB2   = 8'h08;
    // control register field positions
    localparam int         CTRL_PSCK  = 0;
    localparam int         CTRL_BYP   = 1;
    localparam int         CTRL_P1    = 2;
    localparam int         CTRL_GATE  = 4;
    localparam int         CTRL_EDGE  = 5;
    localparam int         CTRL_P2    = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // source divider terminal counts (divide ratio minus one)
    localparam logic [4:0] HALF_LIM   = 5'h01;
    localparam logic [4:0] DIV4_LIM   = 5'h03;
    localparam logic [4:0] DIV32_LIM  = 5'h1f;
    // axi response codes
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLV   = 2'h2;
    // second timebase source modes, coded {gate, edge}
    localparam logic [1:0] MODE_RISE  = 2'h0;
    localparam logic [1:0] MODE_FALL  = 2'h1;
    localparam logic [1:0] MODE_GATED = 2'h2;
    localparam logic [1:0] MODE_BOTH  = 2'h3;
endpackage : tbps_pkg

// [tbps_pin_src.sv]
// partner model: clock source driving the second timebase pin
// assumes the bench raises run for whole pin periods only
`timescale 1ns/10ps
`default_nettype none
module tbps_pin_src (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       run,
    input  wire logic [3:0] half,
    output var  logic       pin
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic       pin_next;
    // each phase lasts half cycles; half of two or more keeps every edge visible
    always_comb begin
        cnt_next = cnt_reg + 4'h1;
        pin_next = pin;
        if (!run) begin
            cnt_next = 4'h0;
        end else if (cnt_reg == half - 4'h1) begin
            cnt_next = 4'h0;
            pin_next = ~pin;
        end
    end
    // pin rests low between bursts so a mode change never sees a stray edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 4'h0;
            pin     <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            pin     <= pin_next;
        end
    end
endmodule : tbps_pin_src
`default_nettype wire

// [tbps_bench.sv]
// self-checking bench for the timebase prescaler and clock select block
// assumes the pin partner model and an axi4-lite master built from tasks here
`timescale 1ns/10ps
`default_nettype none
module tbps_bench;
    import tbps_pkg::*;
    typedef struct packed {logic [7:0] ctrl; logic kind; logic [15:0] exp;} tbps_row_s;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, run;
    logic        awready, wready, bvalid, arready, rvalid, pin;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0]  wstrb, half;
    logic [1:0]  bresp, rresp, r;
    logic [15:0] tb1_count, tb2_count;
    int          bad_count = 0;
    int          n_compared = 0;
    int          tb2_sum;
    // kind 0: tb1 tick period in cycles; kind 1: tb2 steps over four pin periods of six cycles
    tbps_row_s   rows [15] = '{'{8'h00, 1'b0, 16'h20}, '{8'h01, 1'b0, 16'h04}, '{8'h02, 1'b0, 16'h02},
        '{8'h03, 1'b0, 16'h02}, '{8'h05, 1'b0, 16'h08}, '{8'h09, 1'b0, 16'h10}, '{8'h0d, 1'b0, 16'h20},
        '{8'h0e, 1'b0, 16'h10}, '{8'h00, 1'b1, 16'h04}, '{8'h20, 1'b1, 16'h04}, '{8'h10, 1'b1, 16'h0c},
        '{8'h30, 1'b1, 16'h08}, '{8'h70, 1'b1, 16'h04}, '{8'hf0, 1'b1, 16'h01}, '{8'h90, 1'b1, 16'h03}};

    tbps_top #(.CNT_W(16)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_clk_in(pin),
        .tb1_count(tb1_count), .tb2_count(tb2_count));
    tbps_pin_src pin_src (.aclk(aclk), .aresetn(aresetn), .run(run), .half(half), .pin(pin));

    // 10 MHz system clock
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic final_report;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // a wait that runs out of its bound ends the run as a failure
    task automatic give_up;
        bad_count++;
        final_report();
    endtask : give_up

    // address and data offered together, each dropped once taken; bready held until bvalid
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] rs);
        int k;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                rs = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (k == 50) give_up();
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        int k;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                rs = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (k == 50) give_up();
    endtask : axi_rd

    // skips two steps so a prescaler phase left by a code change is gone, then times one step
    task automatic tb1_period(output logic [31:0] p);
        int          k;
        logic [15:0] last;
        repeat (2) begin
            last = tb1_count;
            for (k = 0; k < 400 && tb1_count === last; k++) @(posedge aclk);
            if (k == 400) give_up();
        end
        last = tb1_count;
        for (k = 0; k < 400 && tb1_count === last; k++) @(posedge aclk);
        if (k == 400) give_up();
        p = k;
    endtask : tb1_period

    // four whole pin periods, then time for the synchroniser to drain
    task automatic tb2_burst(output logic [31:0] dlt);
        logic [15:0] st;
        st = tb2_count;
        @(posedge aclk);
        run <= 1'b1;
        repeat (24) @(posedge aclk);
        run <= 1'b0;
        repeat (8) @(posedge aclk);
        dlt = {16'h0, tb2_count - st};
    endtask : tb2_burst

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, run, aresetn} = 7'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        half = 4'h3;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        check({16'h0, tb1_count}, 32'h0);
        check({16'h0, tb2_count}, 32'h0);
        axi_rd(ADDR_CTRL, v, r);
        check(v, {24'h0, CTRL_RESET});
        tb2_sum = 0;
        foreach (rows[i]) begin
            axi_wr(ADDR_CTRL, {24'h0, rows[i].ctrl}, 4'h1, r);
            check({30'h0, r}, {30'h0, RESP_OKAY});
            if (!rows[i].kind) begin
                tb1_period(v);
            end else begin
                tb2_burst(v);
                tb2_sum += rows[i].exp; // running total from the table, not from the counter
            end
            check(v, {16'h0, rows[i].exp});
        end
        // counter is read-only; pin idle keeps the running total exact
        axi_wr(ADDR_TB2, 32'hffffffff, 4'hf, r);
        check({30'h0, r}, {30'h0, RESP_OKAY});
        axi_rd(ADDR_TB2, v, r);
        check(v, tb2_sum);
        axi_wr(8'h0c, 32'h000000ff, 4'hf, r);
        check({30'h0, r}, {30'h0, RESP_SLV});
        axi_rd(8'h0c, v, r);
        // response and data compared apart: the check task is one word wide
        check({30'h0, r}, {30'h0, RESP_SLV});
        check(v, 32'h0);
        // strobe lane 0 off leaves the control byte alone
        axi_wr(ADDR_CTRL, 32'h00000001, 4'h0, r);
        axi_rd(ADDR_CTRL, v, r);
        check(v, 32'h00000090);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        check({tb1_count, tb2_count}, 32'h0);
        axi_rd(ADDR_CTRL, v, r);
        check(v, 32'h0);
        final_report();
    end
endmodule : tbps_bench
`default_nettype wire
